// *** inc/pmc_pkg.sv ***
// pmc_pkg: constants and carrier types of the power mode controller
package pmc_pkg;
    //------------------------------------------------------------------
    // timing
    //------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned UNIT_FAST_NS  = 100_000_000;
    localparam int unsigned UNIT_FAST_MS  = 100;
    localparam int unsigned UNIT_SLOW_MS  = 1000;
    localparam int unsigned UNIT_MIN_MS   = 60_000;
    localparam int unsigned TICK_CYC      = UNIT_FAST_NS / CLK_PERIOD_NS;
    localparam int unsigned TICKS_PER_S   = UNIT_SLOW_MS / UNIT_FAST_MS;
    localparam int unsigned TICKS_PER_MIN = UNIT_MIN_MS / UNIT_FAST_MS;

    //------------------------------------------------------------------
    // register indices (byte address is four times the index)
    //------------------------------------------------------------------
    localparam logic [9:0] IDX_RM_ADDR  = 10'h32C;
    localparam logic [9:0] IDX_RM_MASK  = 10'h32D;
    localparam logic [9:0] IDX_MODE     = 10'h330;
    localparam logic [9:0] IDX_PIN_ONDZ = 10'h331;
    localparam logic [9:0] IDX_PIN_SLP  = 10'h332;
    localparam logic [9:0] IDX_PIN_SPND = 10'h333;
    localparam logic [9:0] IDX_MON_CTRL = 10'h334;
    localparam logic [9:0] IDX_DZ_CFG   = 10'h335;
    localparam logic [9:0] IDX_SL_CFG   = 10'h336;

    //------------------------------------------------------------------
    // fields and reset values
    //------------------------------------------------------------------
    localparam int unsigned RESUME_BIT  = 3;
    localparam int unsigned PIN_W       = 6;
    localparam logic [5:0]  PIN_RST     = 6'h07;
    localparam int unsigned ONES_LSB    = 0;
    localparam int unsigned TENS_LSB    = 4;
    localparam int unsigned UNIT_BIT    = 7;
    localparam int unsigned RESTART_BIT = 8;
    localparam int unsigned TMR_EN_BIT  = 9;
    localparam logic [9:0]  DZ_RST      = 10'h100;
    localparam logic [9:0]  DZ_WMASK    = 10'h3FF;
    localparam logic [9:0]  SL_WMASK    = 10'h27F;
    localparam int unsigned MON_MEM_BIT = 0;
    localparam int unsigned MON_EN_BIT  = 1;
    localparam int unsigned MON_HIT_BIT = 4;
    localparam logic [2:0]  MODE_MAX    = 3'h3;

    typedef enum logic [1:0] {
        PMC_ON, PMC_DOZE, PMC_SLEEP, PMC_SUSPEND
    } pmc_mode_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [11:0] address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } pmc_avs_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } pmc_avs_rsp_t;

    typedef struct packed {
        logic        cycle;
        logic        mem;
        logic [19:0] addr;
    } pmc_cpu_t;
endpackage

// *** hw/pmc_top.sv ***
// pmc_top: power mode controller with range monitor and idle timers
//
// Behaviour
// - mask bit 1 compares address bit, 0 ignores
// - I/O uses A15..0, memory uses A19..4
// - monitor address compared against selected CPU bits
// - mode field read/write, 0..3 enters mode
// - resume bit restores previous mode on activity
// - On/Doze drives pins from on/doze levels
// - Sleep drives pins from sleep levels
// - Suspend drives pins from suspend levels
// - pin level fields reset to 0x07
// - doze ones digit bits 3..0, 0..9
// - both doze digits zero disables doze timer
// - doze unit bit selects 100 ms or 1 s
// - doze restart on activity, resets to 1
// - doze enable bit 9, resets to 0
// - sleep config ones, tens, enable bit 9
// - sleep timer counts minutes, zero disables
`timescale 1ns/1ps
module pmc_top
    import pmc_pkg::*;
#(
    parameter int unsigned P_TICK_CYC = pmc_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_arst_n,
    // register bus
    input  wire pmc_pkg::pmc_avs_req_t i_avs,
    output      pmc_pkg::pmc_avs_rsp_t o_avs,
    // cpu bus and activity pins
    input  wire pmc_pkg::pmc_cpu_t     i_cpu,
    input  wire logic                  i_activity,
    // power control pins and state
    output      logic [5:0]            o_pwr_pin,
    output      logic [1:0]            o_mode
);
    import pmc_pkg::*;

    //------------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------------
    pmc_cpu_t    cpu_s1_q;
    pmc_cpu_t    cpu_s2_q;
    logic        act_s1_q;
    logic        act_s2_q;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cpu_s1_q <= '0;
            cpu_s2_q <= '0;
            act_s1_q <= 1'b0;
            act_s2_q <= 1'b0;
        end else begin
            cpu_s1_q <= i_cpu;
            cpu_s2_q <= cpu_s1_q;
            act_s1_q <= i_activity;
            act_s2_q <= act_s1_q;
        end
    end

    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    logic [15:0] rm_addr_q;
    logic [15:0] rm_mask_q;
    logic [1:0]  mon_q;
    pmc_mode_t   mode_q;
    pmc_mode_t   mode_d;
    pmc_mode_t   prev_q;
    pmc_mode_t   prev_d;
    logic        resume_q;
    logic [5:0]  ondz_q;
    logic [5:0]  slp_q;
    logic [5:0]  spnd_q;
    logic [9:0]  dz_q;
    logic [9:0]  sl_q;
    logic [5:0]  pin_q;
    logic        ack_q;
    logic [31:0] rdata_q;

    //------------------------------------------------------------------
    // bus decode
    //------------------------------------------------------------------
    wire        req      = i_avs.read | i_avs.write;
    wire [9:0]  idx      = i_avs.address[11:2];
    wire        wr_take  = i_avs.write & ack_q;
    wire [15:0] wmask    = {{8{i_avs.byteenable[1]}},
                            {8{i_avs.byteenable[0]}}};
    wire        wsel_ra  = wr_take && idx == IDX_RM_ADDR;
    wire        wsel_rm  = wr_take && idx == IDX_RM_MASK;
    wire        wsel_md  = wr_take && idx == IDX_MODE;
    wire        wsel_po  = wr_take && idx == IDX_PIN_ONDZ;
    wire        wsel_ps  = wr_take && idx == IDX_PIN_SLP;
    wire        wsel_pp  = wr_take && idx == IDX_PIN_SPND;
    wire        wsel_mc  = wr_take && idx == IDX_MON_CTRL;
    wire        wsel_dz  = wr_take && idx == IDX_DZ_CFG;
    wire        wsel_sl  = wr_take && idx == IDX_SL_CFG;

    // byte-lane merge of write data over the old 16-bit value
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    wire [15:0] mode_rd  = {12'h000, resume_q, 1'b0, mode_q};
    wire [15:0] mode_wv  = merge(mode_rd, i_avs.writedata[15:0], wmask);
    wire        mode_ok  = mode_wv[2:0] <= MODE_MAX;

    assign o_avs = '{waitrequest: req & ~ack_q, readdata: rdata_q};
    assign o_mode            = mode_q;
    assign o_pwr_pin         = pin_q;

    //------------------------------------------------------------------
    // range monitor
    //------------------------------------------------------------------
    wire        mon_mem  = mon_q[MON_MEM_BIT];
    wire        mon_en   = mon_q[MON_EN_BIT];
    wire [15:0] cpu_sel  = mon_mem ? cpu_s2_q.addr[19:4]
                                   : cpu_s2_q.addr[15:0];
    wire [15:0] diff     = (cpu_sel ^ rm_addr_q) & rm_mask_q;
    wire        rm_hit   = mon_en & cpu_s2_q.cycle
                         & (cpu_s2_q.mem == mon_mem)
                         & (diff == 16'h0000);
    wire        act      = rm_hit | act_s2_q;

    //------------------------------------------------------------------
    // prescaler: 100 ms tick, second and minute pulses
    //------------------------------------------------------------------
    logic [21:0] tick_cnt_q;
    logic [3:0]  sec_cnt_q;
    logic [9:0]  min_cnt_q;
    wire tick_p = tick_cnt_q == 22'(P_TICK_CYC - 1);
    wire sec_p  = tick_p && sec_cnt_q == 4'(TICKS_PER_S - 1);
    wire min_p  = tick_p && min_cnt_q == 10'(TICKS_PER_MIN - 1);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt_q <= '0;
            sec_cnt_q  <= '0;
            min_cnt_q  <= '0;
        end else begin
            tick_cnt_q <= tick_p ? 22'h0 : tick_cnt_q + 22'h1;
            if (tick_p) begin
                sec_cnt_q <= sec_p ? 4'h0 : sec_cnt_q + 4'h1;
                min_cnt_q <= min_p ? 10'h0 : min_cnt_q + 10'h1;
            end
        end
    end

    //------------------------------------------------------------------
    // doze and sleep timers
    //------------------------------------------------------------------
    wire [3:0] dz_ones  = dz_q[ONES_LSB +: 4];
    wire [2:0] dz_tens  = dz_q[TENS_LSB +: 3];
    wire [6:0] dz_lim   = 7'(dz_tens) * 7'd10 + 7'(dz_ones);
    wire       dz_unit  = dz_q[UNIT_BIT] ? sec_p : tick_p;
    wire       dz_rst   = act & dz_q[RESTART_BIT];
    wire       dz_arm   = dz_q[TMR_EN_BIT]
                        && dz_lim != 7'h00
                        && mode_q == PMC_ON;
    wire [3:0] sl_ones  = sl_q[ONES_LSB +: 4];
    wire [2:0] sl_tens  = sl_q[TENS_LSB +: 3];
    wire [6:0] sl_lim   = 7'(sl_tens) * 7'd10 + 7'(sl_ones);
    wire       sl_arm   = sl_q[TMR_EN_BIT]
                        && sl_lim != 7'h00
                        && mode_q == PMC_DOZE;
    logic [6:0] dz_cnt_q;
    logic [6:0] sl_cnt_q;
    wire dz_exp = dz_arm & dz_unit & ~dz_rst
                & (dz_cnt_q == dz_lim - 7'h01);
    wire sl_exp = sl_arm & min_p & ~act
                & (sl_cnt_q == sl_lim - 7'h01);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dz_cnt_q <= '0;
            sl_cnt_q <= '0;
        end else begin
            if (!dz_arm || dz_rst || dz_exp)
                dz_cnt_q <= 7'h00;
            else if (dz_unit)
                dz_cnt_q <= dz_cnt_q + 7'h01;
            if (!sl_arm || act || sl_exp)
                sl_cnt_q <= 7'h00;
            else if (min_p)
                sl_cnt_q <= sl_cnt_q + 7'h01;
        end
    end

    //------------------------------------------------------------------
    // mode sequencing
    //------------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        prev_d = prev_q;
        if (wsel_md && mode_ok) begin
            mode_d = pmc_mode_t'(mode_wv[1:0]);
            prev_d = mode_q;
        end else if (act && resume_q && mode_q != prev_q) begin
            mode_d = prev_q;
        end else if (dz_exp) begin
            mode_d = PMC_DOZE;
            prev_d = mode_q;
        end else if (sl_exp) begin
            mode_d = PMC_SLEEP;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_q <= PMC_ON;
            prev_q <= PMC_ON;
        end else begin
            mode_q <= mode_d;
            prev_q <= prev_d;
        end
    end

    //------------------------------------------------------------------
    // power control pins
    //------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_q <= PIN_RST;
        end else begin
            case (mode_q)
                PMC_ON, PMC_DOZE: pin_q <= ondz_q;
                PMC_SLEEP:        pin_q <= slp_q;
                PMC_SUSPEND:      pin_q <= spnd_q;
                default:          pin_q <= ondz_q;
            endcase
        end
    end

    //------------------------------------------------------------------
    // register writes
    //------------------------------------------------------------------
    wire [15:0] wd = i_avs.writedata[15:0];
    wire [15:0] mc_wv = merge({14'h0000, mon_q}, wd, wmask);
    wire [15:0] po_wv = merge({10'h000, ondz_q}, wd, wmask);
    wire [15:0] ps_wv = merge({10'h000, slp_q}, wd, wmask);
    wire [15:0] pp_wv = merge({10'h000, spnd_q}, wd, wmask);
    wire [15:0] dz_wv = merge({6'h00, dz_q}, wd, wmask);
    wire [15:0] sl_wv = merge({6'h00, sl_q}, wd, wmask);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rm_addr_q <= '0;
            rm_mask_q <= '0;
            mon_q     <= '0;
            resume_q  <= 1'b0;
            ondz_q    <= PIN_RST;
            slp_q     <= PIN_RST;
            spnd_q    <= PIN_RST;
            dz_q      <= DZ_RST;
            sl_q      <= '0;
        end else begin
            if (wsel_ra) rm_addr_q <= merge(rm_addr_q, wd, wmask);
            if (wsel_rm) rm_mask_q <= merge(rm_mask_q, wd, wmask);
            if (wsel_mc) mon_q <= mc_wv[1:0];
            if (wsel_md) resume_q <= mode_wv[RESUME_BIT];
            if (wsel_po) ondz_q <= po_wv[5:0];
            if (wsel_ps) slp_q <= ps_wv[5:0];
            if (wsel_pp) spnd_q <= pp_wv[5:0];
            if (wsel_dz) dz_q <= dz_wv[9:0] & DZ_WMASK;
            if (wsel_sl) sl_q <= sl_wv[9:0] & SL_WMASK;
        end
    end

    //------------------------------------------------------------------
    // read mux and handshake
    //------------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb begin
        case (idx)
            IDX_RM_ADDR:  rd_mux = rm_addr_q;
            IDX_RM_MASK:  rd_mux = rm_mask_q;
            IDX_MODE:     rd_mux = mode_rd;
            IDX_PIN_ONDZ: rd_mux = {10'h000, ondz_q};
            IDX_PIN_SLP:  rd_mux = {10'h000, slp_q};
            IDX_PIN_SPND: rd_mux = {10'h000, spnd_q};
            IDX_MON_CTRL: rd_mux = {11'h000, rm_hit, 2'h0, mon_q};
            IDX_DZ_CFG:   rd_mux = {6'h00, dz_q};
            IDX_SL_CFG:   rd_mux = {6'h00, sl_q};
            default:      rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= req & ~ack_q;
            if (i_avs.read && !ack_q)
                rdata_q <= {16'h0000, rd_mux};
        end
    end

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    sequence s_legal_wr;
        wsel_md && mode_ok;
    endsequence
    sequence s_resume_ev;
        act && resume_q && mode_q != prev_q && !wsel_md;
    endsequence

    AST_MASK_IGNORE: assert property (
        (mon_en && cpu_s2_q.cycle && cpu_s2_q.mem == mon_mem
         && rm_mask_q == 16'h0000) |-> rm_hit)
        else $error("zero mask did not match");
    AST_IO_MATCH: assert property (
        (mon_en && !mon_mem && cpu_s2_q.cycle && !cpu_s2_q.mem
         && rm_mask_q == 16'hFFFF) |-> rm_hit == (cpu_s2_q.addr[15:0]
         == rm_addr_q))
        else $error("i/o compare wrong");
    AST_MEM_MATCH: assert property (
        (mon_en && mon_mem && cpu_s2_q.cycle && cpu_s2_q.mem
         && rm_mask_q == 16'hFFFF) |-> rm_hit == (cpu_s2_q.addr[19:4]
         == rm_addr_q))
        else $error("memory compare wrong");
    AST_MODE_WRITE: assert property (
        s_legal_wr |=> mode_q == $past(mode_wv[1:0]) ##1
        o_pwr_pin == $past(mode_q == PMC_SLEEP ? slp_q
                    : mode_q == PMC_SUSPEND ? spnd_q : ondz_q))
        else $error("mode write not taken");
    AST_RESUME: assert property (
        s_resume_ev |=> mode_q == $past(prev_q))
        else $error("resume did not restore mode");
    AST_PIN_ONDZ: assert property (
        (mode_q == PMC_ON || mode_q == PMC_DOZE) |=> pin_q == $past(ondz_q))
        else $error("on/doze pins wrong");
    AST_PIN_SLP: assert property (
        mode_q == PMC_SLEEP |=> pin_q == $past(slp_q))
        else $error("sleep pins wrong");
    AST_PIN_SPND: assert property (
        mode_q == PMC_SUSPEND |=> pin_q == $past(spnd_q))
        else $error("suspend pins wrong");
    AST_DZ_ZERO: assert property (
        dz_lim == 7'h00 |-> !dz_exp ##1 dz_cnt_q == 7'h00)
        else $error("zero doze timer ran");
    AST_DZ_RESTART: assert property (
        (dz_rst && mode_q == PMC_ON) |=> dz_cnt_q == 7'h00)
        else $error("activity did not restart doze");
    AST_DZ_EXPIRE: assert property (
        (dz_exp && !wsel_md && !(act && resume_q && mode_q != prev_q))
        |=> mode_q == PMC_DOZE ##1 pin_q == ondz_q)
        else $error("doze expiry not taken");
    AST_SL_UNIT: assert property (
        sl_cnt_q != $past(sl_cnt_q) |-> sl_cnt_q == 7'h00
        || $past(min_p))
        else $error("sleep counted off minute");
    AST_BUS_ANSWER: assert property (
        (req && o_avs.waitrequest) |=> !o_avs.waitrequest)
        else $error("bus answer late");
    AST_RSVD_ZERO: assert property (
        (i_avs.read && !o_avs.waitrequest) |-> rdata_q[31:16] == 16'h0000
        && (idx != IDX_SL_CFG || rdata_q[8:7] == 2'b00))
        else $error("reserved bits not zero");
endmodule // pmc_top

// *** verif/pmc_cpu_model.sv ***
// pmc_cpu_model: behavioural host cpu bus issuing monitored cycles
`timescale 1ns/1ps
module pmc_cpu_model
    import pmc_pkg::*;
(
    // clock
    input  wire logic              i_clk_sys,
    // cpu bus towards the block
    output      pmc_pkg::pmc_cpu_t o_cpu
);
    initial begin
        o_cpu = '{cycle: 1'b0, mem: 1'b0, addr: 20'h00000};
    end

    //------------------------------------------------------------------
    // one bus cycle held four clocks
    //------------------------------------------------------------------
    task automatic run(input logic mem, input logic [19:0] addr);
        @(posedge i_clk_sys);
        o_cpu <= '{cycle: 1'b1, mem: mem, addr: addr};
        repeat (4) @(posedge i_clk_sys);
        // released lines show the inverse, never the stale value
        o_cpu <= '{cycle: 1'b0, mem: ~mem, addr: ~addr};
    endtask
endmodule // pmc_cpu_model

// *** verif/power_mode_controller_tb.sv ***
// power_mode_controller_tb: register, pin, monitor and timer checks
`timescale 1ns/1ps
module power_mode_controller_tb;
    import pmc_pkg::*;
    localparam int unsigned TK = 10;
    logic         i_clk_sys;
    logic         i_arst_n;
    logic         i_activity;
    pmc_avs_req_t i_avs;
    pmc_avs_rsp_t o_avs;
    pmc_cpu_t     cpu_s;
    logic [5:0]   o_pwr_pin;
    logic [1:0]   o_mode;
    int           errors;
    int           tests_run;
    logic [9:0]   ridx [10] = '{IDX_RM_ADDR, IDX_RM_MASK, IDX_MODE,
        IDX_PIN_ONDZ, IDX_PIN_SLP, IDX_PIN_SPND, IDX_MON_CTRL,
        IDX_DZ_CFG, IDX_SL_CFG, 10'h000};
    logic [15:0]  rrst [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0007,
        16'h0007, 16'h0007, 16'h0000, 16'h0100, 16'h0000, 16'h0000};
    logic [15:0]  rful [10] = '{16'hFFFF, 16'hFFFF, 16'h0008, 16'h003F,
        16'h003F, 16'h003F, 16'h0003, 16'h03FF, 16'h027F, 16'h0000};
    logic [15:0]  pexp [4] = '{16'h0015, 16'h0015, 16'h002A, 16'h0031};
    logic [15:0]  mctl [7] = '{16'h0002, 16'h0002, 16'h0002, 16'h0003,
        16'h0003, 16'h0003, 16'h0001};
    logic [15:0]  mmsk [7] = '{16'hFF00, 16'hFF00, 16'hFF00, 16'hFF00,
        16'hFF00, 16'h0000, 16'h0000};
    logic         mmem [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [19:0]  madr [7] = '{20'h012AB, 20'h013AB, 20'h12AB0,
        20'h12AB0, 20'h012AB, 20'hFFFFF, 20'h12AB0};
    logic [1:0]   mexp [7] = '{2'h0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 2'h3};

    pmc_top #(.P_TICK_CYC(TK)) dut_u (
        .i_clk_sys  (i_clk_sys),
        .i_arst_n   (i_arst_n),
        .i_avs      (i_avs),
        .o_avs      (o_avs),
        .i_cpu      (cpu_s),
        .i_activity (i_activity),
        .o_pwr_pin  (o_pwr_pin),
        .o_mode     (o_mode)
    );
    pmc_cpu_model cpu_u (
        .i_clk_sys (i_clk_sys),
        .o_cpu     (cpu_s)
    );

    initial i_clk_sys = 1'b0;
    always #12.5 i_clk_sys = ~i_clk_sys;

    //------------------------------------------------------------------
    // compare, bus and wait tasks
    //------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [9:0] idx,
                        input logic [15:0] wd, output logic [15:0] rd);
        int n;
        i_avs <= '{read: ~wr, write: wr, address: {idx, 2'b00},
                   writedata: {16'h0000, wd}, byteenable: 4'hF};
        n = 0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (o_avs.waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            chk(16'(n), 16'h0000);
            finish_test();
        end
        @(posedge i_clk_sys);
        rd = o_avs.readdata[15:0];
        i_avs <= '0;
        @(posedge i_clk_sys);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        logic [15:0] x;
        xfer(1'b1, idx, d, x);
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [15:0] e);
        logic [15:0] x;
        xfer(1'b0, idx, 16'h0000, x);
        chk(x, e);
    endtask
    task automatic wait_mode(input logic [1:0] e, input int lo,
                             input int hi);
        int n;
        n = 0;
        while (o_mode !== e && n < hi) begin
            @(negedge i_clk_sys);
            n++;
        end
        @(posedge i_clk_sys);
        chk({14'h0000, o_mode}, {14'h0000, e});
        if (o_mode !== e) finish_test();
        if (n < lo) chk(16'(n), 16'(lo));
    endtask
    task automatic hold_mode(input logic [1:0] e, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(negedge i_clk_sys);
            if (o_mode !== e) bad++;
        end
        @(posedge i_clk_sys);
        chk(16'(bad), 16'h0000);
    endtask
    task automatic act_pulses(input int k);
        repeat (k) begin
            i_activity <= 1'b1;
            repeat (2) @(posedge i_clk_sys);
            i_activity <= 1'b0;
            repeat (13) @(posedge i_clk_sys);
        end
    endtask
    task automatic doze_go(input logic [15:0] cfg);
        wr(IDX_DZ_CFG, 16'h0000);
        wr(IDX_MODE, 16'h0000);
        wr(IDX_DZ_CFG, cfg);
    endtask
    task automatic finish_test();
        $display("Summary errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        errors = 0;
        tests_run = 0;
        i_arst_n = 1'b0;
        i_activity = 1'b0;
        i_avs = '0;
        repeat (10) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        @(posedge i_clk_sys);
        chk({10'h000, o_pwr_pin}, 16'h0007);
        for (int i = 0; i < 10; i++) begin
            rdc(ridx[i], rrst[i]);
            wr(ridx[i], 16'hFFFF);
            rdc(ridx[i], rful[i]);
            wr(ridx[i], rrst[i]);
        end
        wr(IDX_PIN_ONDZ, 16'h0015);
        wr(IDX_PIN_SLP, 16'h002A);
        wr(IDX_PIN_SPND, 16'h0031);
        for (int m = 0; m < 4; m++) begin
            wr(IDX_MODE, 16'(m));
            repeat (4) @(posedge i_clk_sys);
            chk({14'h0000, o_mode}, 16'(m));
            chk({10'h000, o_pwr_pin}, pexp[m]);
        end
        wr(IDX_MODE, 16'h0006);
        hold_mode(2'h3, 8);
        wr(IDX_RM_ADDR, 16'h1234);
        for (int i = 0; i < 7; i++) begin
            wr(IDX_MON_CTRL, mctl[i]);
            wr(IDX_RM_MASK, mmsk[i]);
            wr(IDX_MODE, 16'h0000);
            wr(IDX_MODE, 16'h000B);
            rdc(IDX_MODE, 16'h000B);
            cpu_u.run(mmem[i], madr[i]);
            repeat (8) @(posedge i_clk_sys);
            chk({14'h0000, o_mode}, {14'h0000, mexp[i]});
        end
        wr(IDX_MON_CTRL, 16'h0000);
        doze_go(16'h0303);
        wait_mode(2'h1, 2 * TK, 4 * TK + 8);
        doze_go(16'h0310);
        wait_mode(2'h1, 9 * TK, 11 * TK + 8);
        doze_go(16'h0382);
        wait_mode(2'h1, 10 * TK, 30 * TK + 8);
        doze_go(16'h0300);
        hold_mode(2'h0, 20 * TK);
        doze_go(16'h0103);
        hold_mode(2'h0, 20 * TK);
        doze_go(16'h0303);
        act_pulses(8);
        chk({14'h0000, o_mode}, 16'h0000);
        wait_mode(2'h1, TK, 4 * TK + 8);
        doze_go(16'h0203);
        act_pulses(4);
        chk({14'h0000, o_mode}, 16'h0001);
        wr(IDX_SL_CFG, 16'h0201);
        doze_go(16'h0303);
        wait_mode(2'h1, 2 * TK, 4 * TK + 8);
        wait_mode(2'h2, 0, 1200 * TK + 8);
        finish_test();
    end
endmodule // power_mode_controller_tb
